/* File: design/eimv_regs.vh */
// Register map, field positions, reset values and vector codes of the
// E1 interrupt mask and vector block.
// Assumes an 8-bit register address and 8-bit register data.
`ifndef EIMV_REGS_VH
`define EIMV_REGS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define EIMV_OFS_MATCH_WORD 8'h18
`define EIMV_OFS_MATCH_MASK 8'h19
`define EIMV_OFS_CONTROL 8'h1A
`define EIMV_OFS_ERR_EN 8'h1C
`define EIMV_OFS_OVF_EN 8'h1D
`define EIMV_OFS_SYNC_EN 8'h1E
`define EIMV_OFS_TRIG_ARM 8'h20
`define EIMV_OFS_VECTOR 8'h21

// ----------------------------------------------------------------------
// Reset values and writable bits
// ----------------------------------------------------------------------
`define EIMV_RST_BYTE 8'h00
`define EIMV_ERR_EN_BITS 8'hFD
`define EIMV_OVF_EN_BITS 8'hFE
`define EIMV_SYNC_EN_BITS 8'hFF
`define EIMV_CONTROL_BITS 8'h40

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define EIMV_CTL_SUSPEND 6
// Error event enable word
`define EIMV_FAR_CRC_REPORT 7
`define EIMV_LOCAL_CRC_ERR 6
`define EIMV_DOUBLE_ALIGN_ERR 5
`define EIMV_LINE_VIOLATION 4
`define EIMV_ALARM_CRC_COUNT 3
`define EIMV_BIT_ERR 2
`define EIMV_SIGNALLING_CHANGE 0
// Counter overflow enable word
`define EIMV_FAR_CRC_CNT_WRAP 7
`define EIMV_LOCAL_CRC_CNT_WRAP 6
`define EIMV_CRC_ALIGN_CHANGE 5
`define EIMV_ALIGN_ERR_CNT_WRAP 4
`define EIMV_ALARM_CRC_CNT_WRAP 3
`define EIMV_BIT_ERR_CNT_WRAP 2
`define EIMV_AUX_PATTERN 1
// Sync, alarm and pattern enable word
`define EIMV_SIG_MF_LOSS 7
`define EIMV_CRC_MF_LOSS 6
`define EIMV_FAR_FAILURE 5
`define EIMV_FAR_MF_ALARM 4
`define EIMV_SECOND_TICK 3
`define EIMV_BUFFER_HALT 2
`define EIMV_BUFFER_BEGIN 1
`define EIMV_CODE_WORD 0
// Buffer trigger arm word
`define EIMV_ARM_BEGIN0_MIS 7
`define EIMV_ARM_BEGIN0_HIT 6
`define EIMV_ARM_BEGIN1_MIS 5
`define EIMV_ARM_BEGIN1_HIT 4
`define EIMV_ARM_HALT0_MIS 3
`define EIMV_ARM_HALT0_HIT 2
`define EIMV_ARM_HALT1_MIS 1
`define EIMV_ARM_HALT1_HIT 0

// ----------------------------------------------------------------------
// Vector categories
// ----------------------------------------------------------------------
`define EIMV_VEC_SYNC 8'h80
`define EIMV_VEC_PATTERN 8'h40
`define EIMV_VEC_ERROR 8'h20
`define EIMV_VEC_OVERFLOW 8'h10
`define EIMV_VEC_TIMING 8'h08
`define EIMV_VEC_CODE 8'h02
`define EIMV_VEC_SIGNAL 8'h01
`define EIMV_COUNT_MAX 8'hFF
`define EIMV_COUNT_ZERO 8'h00

`endif

/* File: design/eimv_code_match.v */
// Masked code word comparator for the receive time slot stream.
// Assumes one received byte per valid strobe, on the block clock.
`timescale 1ns/100ps
`include "eimv_regs.vh"

module eimv_code_match (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Received slot data
  input wire [7:0] rx_byte,
  input wire rx_byte_valid,
  input wire rx_slot_selected,
  // Settings
  input wire [7:0] code_match_word,
  input wire [7:0] code_match_mask,
  input wire [7:0] trig_arm,
  // One-cycle hits
  output reg data_hit_q,
  output reg begin_hit_q,
  output reg halt_hit_q
);

  // --------------------------------------------------------------------
  // Compare
  // --------------------------------------------------------------------
  // Only positions with a mask bit of one take part
  wire same = ((rx_byte ^ code_match_word) & code_match_mask) == 8'h00;
  wire hit = rx_byte_valid & same;
  wire miss = rx_byte_valid & ~same;

  // A start or stop fires on its own armed match or mismatch
  wire begin_d = (trig_arm[`EIMV_ARM_BEGIN0_MIS] & miss)
    | (trig_arm[`EIMV_ARM_BEGIN0_HIT] & hit)
    | (trig_arm[`EIMV_ARM_BEGIN1_MIS] & miss)
    | (trig_arm[`EIMV_ARM_BEGIN1_HIT] & hit);
  wire halt_d = (trig_arm[`EIMV_ARM_HALT0_MIS] & miss)
    | (trig_arm[`EIMV_ARM_HALT0_HIT] & hit)
    | (trig_arm[`EIMV_ARM_HALT1_MIS] & miss)
    | (trig_arm[`EIMV_ARM_HALT1_HIT] & hit);

  always @(posedge clk) begin
    if (reset) begin
      data_hit_q <= 1'b0;
      begin_hit_q <= 1'b0;
      halt_hit_q <= 1'b0;
    end else begin
      data_hit_q <= hit & rx_slot_selected;
      begin_hit_q <= begin_d;
      halt_hit_q <= halt_d;
    end
  end

endmodule

/* File: design/eimv_irq_ctrl.v */
// Interrupt enable and vector logic of an E1 receive framer.
// Assumes all event inputs come from framer logic on clk; the
// open-drain request pin is resolved outside from out and enable.
//
// Operation
// - Mask bit one enables its source, zero masks; all reset to zero.
// - Far-end CRC error report via E-bit raises error vector 00100000.
// - Each local multiframe CRC-4 error raises error vector.
// - Two consecutive errored alignment signals raise error vector.
// - Each line bipolar violation raises error vector.
// - Alarm with continuous CRC counter increment raises error vector.
// - Each bit monitor error raises error vector.
// - Any ABCD signalling change raises vector with only bit zero set.
// - E-bit or CRC-4 counter wrap FF to 00 raises overflow vector.
// - Alignment, alarm or bit error counter wrap raises overflow vector.
// - Any change of CRC-4 alignment state raises timing vector.
// - Rising auxiliary pattern status raises pattern vector; falls ignored.
// - Loss of signalling multiframe sync raises sync vector.
// - Loss of CRC-4 multiframe sync raises sync vector.
// - Far-end CRC process failure report raises sync vector.
// - Received far-end multiframe alarm raises sync vector.
// - Each toggle of one-second status raises timing vector.
// - Armed buffer stop match or mismatch raises code vector.
// - Armed buffer start match or mismatch raises code vector.
// - Selected slot data matching code word raises code vector.
// - Suspend floats request output and ignores every source.
// - Code compare uses only positions whose mask bit is one.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps
`include "eimv_regs.vh"

module eimv_irq_ctrl (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata_q,
  // Error event pulses
  input wire ev_far_crc_report,
  input wire ev_local_crc_err,
  input wire ev_align_err,
  input wire ev_line_violation,
  input wire ev_alarm_crc_inc,
  input wire ev_bit_err,
  input wire ev_signalling_change,
  // Error counters
  input wire [7:0] far_crc_cnt,
  input wire [7:0] local_crc_cnt,
  input wire [7:0] align_err_cnt,
  input wire [7:0] alarm_crc_cnt,
  input wire [7:0] bit_err_cnt,
  // Status levels
  input wire crc_align_state,
  input wire aux_pattern_seen,
  input wire sig_multiframe_lost,
  input wire crc_multiframe_lost,
  input wire far_failure_state,
  input wire far_multiframe_alarm,
  input wire second_tick_state,
  // Received slot data
  input wire [7:0] rx_byte,
  input wire rx_byte_valid,
  input wire rx_byte_is_fas,
  input wire rx_slot_selected,
  // Request pin, open drain, active low
  output reg irq_n_out_q,
  output reg irq_n_oe_q,
  // Pending vector for the host
  output reg [7:0] irq_vector_q
);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // Counter wrap is a step from the maximum straight to zero
  function wrapped;
    input [7:0] prev;
    input [7:0] cur;
    begin
      wrapped = (prev == `EIMV_COUNT_MAX) && (cur == `EIMV_COUNT_ZERO);
    end
  endfunction

  // Store only the implemented bits of a write
  function [7:0] keep_bits;
    input [7:0] data;
    input [7:0] bits;
    begin
      keep_bits = data & bits;
    end
  endfunction

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  reg [7:0] err_en_q;
  reg [7:0] ovf_en_q;
  reg [7:0] sync_en_q;
  reg [7:0] match_word_q;
  reg [7:0] match_mask_q;
  reg [7:0] control_q;
  reg [7:0] trig_arm_q;

  wire wr_err = reg_write && (reg_addr == `EIMV_OFS_ERR_EN);
  wire wr_ovf = reg_write && (reg_addr == `EIMV_OFS_OVF_EN);
  wire wr_sync = reg_write && (reg_addr == `EIMV_OFS_SYNC_EN);
  wire wr_word = reg_write && (reg_addr == `EIMV_OFS_MATCH_WORD);
  wire wr_mask = reg_write && (reg_addr == `EIMV_OFS_MATCH_MASK);
  wire wr_ctl = reg_write && (reg_addr == `EIMV_OFS_CONTROL);
  wire wr_arm = reg_write && (reg_addr == `EIMV_OFS_TRIG_ARM);
  wire rd_vec = reg_read && (reg_addr == `EIMV_OFS_VECTOR);

  always @(posedge clk) begin
    if (reset) begin
      err_en_q <= `EIMV_RST_BYTE;
      ovf_en_q <= `EIMV_RST_BYTE;
      sync_en_q <= `EIMV_RST_BYTE;
      match_word_q <= `EIMV_RST_BYTE;
      match_mask_q <= `EIMV_RST_BYTE;
      control_q <= `EIMV_RST_BYTE;
      trig_arm_q <= `EIMV_RST_BYTE;
    end else begin
      if (wr_err) begin
        err_en_q <= keep_bits(reg_wdata, `EIMV_ERR_EN_BITS);
      end
      if (wr_ovf) begin
        ovf_en_q <= keep_bits(reg_wdata, `EIMV_OVF_EN_BITS);
      end
      if (wr_sync) begin
        sync_en_q <= keep_bits(reg_wdata, `EIMV_SYNC_EN_BITS);
      end
      if (wr_word) begin
        match_word_q <= reg_wdata;
      end
      if (wr_mask) begin
        match_mask_q <= reg_wdata;
      end
      if (wr_ctl) begin
        control_q <= keep_bits(reg_wdata, `EIMV_CONTROL_BITS);
      end
      if (wr_arm) begin
        trig_arm_q <= reg_wdata;
      end
    end
  end

  wire suspend = control_q[`EIMV_CTL_SUSPEND];

  // --------------------------------------------------------------------
  // Previous values for edge and wrap detection
  // --------------------------------------------------------------------
  // Cleared to zero at reset, so a level already high at release counts
  // as an edge; the masks are all clear then, so nothing is raised.
  reg [7:0] far_crc_cnt_q;
  reg [7:0] local_crc_cnt_q;
  reg [7:0] align_err_cnt_q;
  reg [7:0] alarm_crc_cnt_q;
  reg [7:0] bit_err_cnt_q;
  reg crc_align_q;
  reg aux_pattern_q;
  reg sig_mf_lost_q;
  reg crc_mf_lost_q;
  reg far_failure_q;
  reg far_mf_alarm_q;
  reg second_tick_q;
  reg fas_err_last_q;

  always @(posedge clk) begin
    if (reset) begin
      far_crc_cnt_q <= `EIMV_COUNT_ZERO;
      local_crc_cnt_q <= `EIMV_COUNT_ZERO;
      align_err_cnt_q <= `EIMV_COUNT_ZERO;
      alarm_crc_cnt_q <= `EIMV_COUNT_ZERO;
      bit_err_cnt_q <= `EIMV_COUNT_ZERO;
      crc_align_q <= 1'b0;
      aux_pattern_q <= 1'b0;
      sig_mf_lost_q <= 1'b0;
      crc_mf_lost_q <= 1'b0;
      far_failure_q <= 1'b0;
      far_mf_alarm_q <= 1'b0;
      second_tick_q <= 1'b0;
      fas_err_last_q <= 1'b0;
    end else begin
      far_crc_cnt_q <= far_crc_cnt;
      local_crc_cnt_q <= local_crc_cnt;
      align_err_cnt_q <= align_err_cnt;
      alarm_crc_cnt_q <= alarm_crc_cnt;
      bit_err_cnt_q <= bit_err_cnt;
      crc_align_q <= crc_align_state;
      aux_pattern_q <= aux_pattern_seen;
      sig_mf_lost_q <= sig_multiframe_lost;
      crc_mf_lost_q <= crc_multiframe_lost;
      far_failure_q <= far_failure_state;
      far_mf_alarm_q <= far_multiframe_alarm;
      second_tick_q <= second_tick_state;
      // Remember whether the last alignment signal was errored
      if (rx_byte_is_fas) begin
        fas_err_last_q <= ev_align_err;
      end
    end
  end

  // Two alignment signals in a row both in error
  wire double_align = rx_byte_is_fas & ev_align_err & fas_err_last_q;

  // --------------------------------------------------------------------
  // Code word events
  // --------------------------------------------------------------------
  wire data_hit;
  wire begin_hit;
  wire halt_hit;

  eimv_code_match u_match (
    .clk(clk),
    .reset(reset),
    .rx_byte(rx_byte),
    .rx_byte_valid(rx_byte_valid),
    .rx_slot_selected(rx_slot_selected),
    .code_match_word(match_word_q),
    .code_match_mask(match_mask_q),
    .trig_arm(trig_arm_q),
    .data_hit_q(data_hit),
    .begin_hit_q(begin_hit),
    .halt_hit_q(halt_hit)
  );

  // --------------------------------------------------------------------
  // Enabled sources by enable word
  // --------------------------------------------------------------------
  wire [7:0] err_src;
  wire [7:0] ovf_src;
  wire [7:0] sync_src;

  assign err_src[`EIMV_FAR_CRC_REPORT] = ev_far_crc_report;
  assign err_src[`EIMV_LOCAL_CRC_ERR] = ev_local_crc_err;
  assign err_src[`EIMV_DOUBLE_ALIGN_ERR] = double_align;
  assign err_src[`EIMV_LINE_VIOLATION] = ev_line_violation;
  assign err_src[`EIMV_ALARM_CRC_COUNT] = ev_alarm_crc_inc;
  assign err_src[`EIMV_BIT_ERR] = ev_bit_err;
  assign err_src[1] = 1'b0;
  assign err_src[`EIMV_SIGNALLING_CHANGE] = ev_signalling_change;

  assign ovf_src[`EIMV_FAR_CRC_CNT_WRAP] =
    wrapped(far_crc_cnt_q, far_crc_cnt);
  assign ovf_src[`EIMV_LOCAL_CRC_CNT_WRAP] =
    wrapped(local_crc_cnt_q, local_crc_cnt);
  assign ovf_src[`EIMV_CRC_ALIGN_CHANGE] =
    crc_align_state ^ crc_align_q;
  assign ovf_src[`EIMV_ALIGN_ERR_CNT_WRAP] =
    wrapped(align_err_cnt_q, align_err_cnt);
  assign ovf_src[`EIMV_ALARM_CRC_CNT_WRAP] =
    wrapped(alarm_crc_cnt_q, alarm_crc_cnt);
  assign ovf_src[`EIMV_BIT_ERR_CNT_WRAP] =
    wrapped(bit_err_cnt_q, bit_err_cnt);
  assign ovf_src[`EIMV_AUX_PATTERN] =
    aux_pattern_seen & ~aux_pattern_q;
  assign ovf_src[0] = 1'b0;

  assign sync_src[`EIMV_SIG_MF_LOSS] =
    sig_multiframe_lost & ~sig_mf_lost_q;
  assign sync_src[`EIMV_CRC_MF_LOSS] =
    crc_multiframe_lost & ~crc_mf_lost_q;
  assign sync_src[`EIMV_FAR_FAILURE] =
    far_failure_state & ~far_failure_q;
  assign sync_src[`EIMV_FAR_MF_ALARM] =
    far_multiframe_alarm & ~far_mf_alarm_q;
  assign sync_src[`EIMV_SECOND_TICK] =
    second_tick_state ^ second_tick_q;
  assign sync_src[`EIMV_BUFFER_HALT] = halt_hit;
  assign sync_src[`EIMV_BUFFER_BEGIN] = begin_hit;
  assign sync_src[`EIMV_CODE_WORD] = data_hit;

  // A one in the enable word lets the source through
  wire [7:0] err_on = err_src & err_en_q;
  wire [7:0] ovf_on = ovf_src & ovf_en_q;
  wire [7:0] sync_on = sync_src & sync_en_q;

  // Map each enabled source to its vector category
  reg [7:0] raise;
  always @* begin
    raise = 8'h00;
    if (|(err_on & ~(8'h01 << `EIMV_SIGNALLING_CHANGE))) begin
      raise = raise | `EIMV_VEC_ERROR;
    end
    if (err_on[`EIMV_SIGNALLING_CHANGE]) begin
      raise = raise | `EIMV_VEC_SIGNAL;
    end
    if (ovf_on[`EIMV_FAR_CRC_CNT_WRAP] | ovf_on[`EIMV_LOCAL_CRC_CNT_WRAP]
        | ovf_on[`EIMV_ALIGN_ERR_CNT_WRAP]
        | ovf_on[`EIMV_ALARM_CRC_CNT_WRAP]
        | ovf_on[`EIMV_BIT_ERR_CNT_WRAP]) begin
      raise = raise | `EIMV_VEC_OVERFLOW;
    end
    if (ovf_on[`EIMV_CRC_ALIGN_CHANGE] | sync_on[`EIMV_SECOND_TICK]) begin
      raise = raise | `EIMV_VEC_TIMING;
    end
    if (ovf_on[`EIMV_AUX_PATTERN]) begin
      raise = raise | `EIMV_VEC_PATTERN;
    end
    if (sync_on[`EIMV_SIG_MF_LOSS] | sync_on[`EIMV_CRC_MF_LOSS]
        | sync_on[`EIMV_FAR_FAILURE] | sync_on[`EIMV_FAR_MF_ALARM]) begin
      raise = raise | `EIMV_VEC_SYNC;
    end
    if (sync_on[`EIMV_BUFFER_HALT] | sync_on[`EIMV_BUFFER_BEGIN]
        | sync_on[`EIMV_CODE_WORD]) begin
      raise = raise | `EIMV_VEC_CODE;
    end
    // Suspended sources are dropped, not held back for later
    if (suspend) begin
      raise = 8'h00;
    end
  end

  // --------------------------------------------------------------------
  // Pending vector and request pin
  // --------------------------------------------------------------------
  // Reading the vector clears the bits it returned; a category raised
  // in that same cycle stays pending so no event is lost.
  wire [7:0] vec_d = (irq_vector_q & ~(rd_vec ? irq_vector_q : 8'h00))
    | raise;

  always @(posedge clk) begin
    if (reset) begin
      irq_vector_q <= 8'h00;
      irq_n_out_q <= 1'b0;
      irq_n_oe_q <= 1'b0;
    end else begin
      irq_vector_q <= vec_d;
      irq_n_out_q <= 1'b0;
      // Pin floats while suspended, else pulled low while pending
      irq_n_oe_q <= ~suspend & (|vec_d);
    end
  end

  // --------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        `EIMV_OFS_ERR_EN: reg_rdata_q <= err_en_q;
        `EIMV_OFS_OVF_EN: reg_rdata_q <= ovf_en_q;
        `EIMV_OFS_SYNC_EN: reg_rdata_q <= sync_en_q;
        `EIMV_OFS_MATCH_WORD: reg_rdata_q <= match_word_q;
        `EIMV_OFS_MATCH_MASK: reg_rdata_q <= match_mask_q;
        `EIMV_OFS_CONTROL: reg_rdata_q <= control_q;
        `EIMV_OFS_TRIG_ARM: reg_rdata_q <= trig_arm_q;
        `EIMV_OFS_VECTOR: reg_rdata_q <= irq_vector_q;
        default: reg_rdata_q <= 8'h00;
      endcase
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end

endmodule

/* File: test/eimv_irq_ctrl_properties.sv */
// Concurrent checks on the ports of the interrupt mask and vector block.
// Assumes the host uses the single-cycle strobe register port.
`timescale 1ns/100ps
`include "eimv_regs.vh"

module eimv_irq_ctrl_chk (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  input wire [7:0] reg_rdata_q,
  // Watched sources
  input wire ev_bit_err,
  input wire ev_signalling_change,
  input wire [7:0] bit_err_cnt,
  input wire aux_pattern_seen,
  // Request and vector
  input wire irq_n_out_q,
  input wire irq_n_oe_q,
  input wire [7:0] irq_vector_q
);
  // Shadow of enables and suspend, rebuilt from observed writes only
  reg [7:0] err_en_q;
  reg [7:0] ovf_en_q;
  reg susp_q;
  wire ctl_wr = reg_write && reg_addr == `EIMV_OFS_CONTROL;
  always @(posedge clk) begin
    if (reset) begin
      err_en_q <= 8'h00;
      ovf_en_q <= 8'h00;
      susp_q <= 1'b0;
    end else if (reg_write) begin
      if (reg_addr == `EIMV_OFS_ERR_EN)
        err_en_q <= reg_wdata & `EIMV_ERR_EN_BITS;
      if (reg_addr == `EIMV_OFS_OVF_EN)
        ovf_en_q <= reg_wdata & `EIMV_OVF_EN_BITS;
      if (ctl_wr)
        susp_q <= reg_wdata[6];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_pin_low; irq_n_out_q == 1'b0; endproperty
  property p_err; ev_bit_err && err_en_q[2] && !susp_q |=> irq_vector_q[5];
  endproperty
  property p_sig;
    ev_signalling_change && err_en_q[0] && !susp_q |=> irq_vector_q[0];
  endproperty
  property p_wrap;
    $past(bit_err_cnt) == 8'hFF && bit_err_cnt == 8'h00 && ovf_en_q[2]
      && !susp_q |=> irq_vector_q[4];
  endproperty
  property p_aux;
    $rose(aux_pattern_seen) && ovf_en_q[1] && !susp_q |=> irq_vector_q[6];
  endproperty
  property p_oe;
    !$past(ctl_wr) |-> irq_n_oe_q == (irq_vector_q != 8'h00 && !susp_q);
  endproperty
  property p_rd_vec;
    reg_read && reg_addr == `EIMV_OFS_VECTOR |=>
      reg_rdata_q == $past(irq_vector_q);
  endproperty
  property p_rd_idle; !reg_read |=> reg_rdata_q == 8'h00; endproperty
  // No category may newly appear while suspended; a read may still clear
  property p_susp;
    susp_q |=> (irq_vector_q & ~$past(irq_vector_q)) == 8'h00;
  endproperty

  a_pin_low: assert property (p_pin_low)
    else $error("request pin not low");
  a_err: assert property (p_err)
    else $error("bit error vector missing");
  a_sig: assert property (p_sig)
    else $error("signalling vector missing");
  a_wrap: assert property (p_wrap)
    else $error("counter wrap vector missing");
  a_aux: assert property (p_aux)
    else $error("pattern vector missing");
  a_oe: assert property (p_oe)
    else $error("request enable wrong");
  a_rd_vec: assert property (p_rd_vec)
    else $error("vector read data wrong");
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero");
  a_susp: assert property (p_susp)
    else $error("event raised while suspended");

  c_err: cover property (ev_bit_err && err_en_q[2]);
  c_rd: cover property (reg_read && reg_addr == 8'h21 && irq_vector_q != 0);
  c_susp: cover property (susp_q && irq_vector_q != 8'h00);
  c_wrap: cover property ($past(bit_err_cnt) == 8'hFF && bit_err_cnt == 0);
endmodule

bind eimv_irq_ctrl eimv_irq_ctrl_chk u_chk (
  .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata_q(reg_rdata_q),
  .ev_bit_err(ev_bit_err), .ev_signalling_change(ev_signalling_change),
  .bit_err_cnt(bit_err_cnt), .aux_pattern_seen(aux_pattern_seen),
  .irq_n_out_q(irq_n_out_q), .irq_n_oe_q(irq_n_oe_q),
  .irq_vector_q(irq_vector_q)
);

/* File: test/eimv_host_model.sv */
// Host processor model driving the register port of the block.
// Assumes the slave never stalls; read data stand one cycle late.
`timescale 1ns/100ps

module eimv_host_model (
  // Clock
  input wire clk,
  // Register port
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_write,
  output logic reg_read,
  input wire [7:0] reg_rdata_q
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  // Data are taken at the edge that ends their only valid cycle
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(posedge clk);
    d = reg_rdata_q;
  endtask
endmodule

/* File: test/e1_interrupt_mask_vector_tb.sv */
// Self-checking bench of the interrupt mask and vector block.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  num_errors++; $display("wrong value at %0t: got %h exp %h", \
  $time, g, e); end end

module e1_interrupt_mask_vector_tb;
  logic clk, reset, aerr, rx_valid, rx_fas, rx_sel, out_n, oe;
  logic reg_write, reg_read;
  logic [7:0] reg_addr, reg_wdata, rdata, rx_byte, vec, d;
  logic [5:0] ev;
  logic [6:0] lv;
  logic [7:0] cnt [5];
  logic [31:0] r;
  int num_errors, checks_done, cycles;

  eimv_host_model host (.clk(clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata_q(rdata));
  eimv_irq_ctrl uut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata_q(rdata), .ev_far_crc_report(ev[0]),
    .ev_local_crc_err(ev[1]), .ev_align_err(aerr),
    .ev_line_violation(ev[2]), .ev_alarm_crc_inc(ev[3]),
    .ev_bit_err(ev[4]), .ev_signalling_change(ev[5]),
    .far_crc_cnt(cnt[0]), .local_crc_cnt(cnt[1]), .align_err_cnt(cnt[2]),
    .alarm_crc_cnt(cnt[3]), .bit_err_cnt(cnt[4]),
    .crc_align_state(lv[0]), .aux_pattern_seen(lv[1]),
    .sig_multiframe_lost(lv[2]), .crc_multiframe_lost(lv[3]),
    .far_failure_state(lv[4]), .far_multiframe_alarm(lv[5]),
    .second_tick_state(lv[6]), .rx_byte(rx_byte), .rx_byte_valid(rx_valid),
    .rx_byte_is_fas(rx_fas), .rx_slot_selected(rx_sel),
    .irq_n_out_q(out_n), .irq_n_oe_q(oe), .irq_vector_q(vec));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Source table: enable word, enable bits, expected vector
  function automatic [17:0] info(input int i);
    case (i)
      0: info = {2'd0, 8'h80, 8'h20};
      1: info = {2'd0, 8'h40, 8'h20};
      2: info = {2'd0, 8'h10, 8'h20};
      3: info = {2'd0, 8'h08, 8'h20};
      4: info = {2'd0, 8'h04, 8'h20};
      5: info = {2'd0, 8'h01, 8'h01};
      6: info = {2'd1, 8'h80, 8'h10};
      7: info = {2'd1, 8'h40, 8'h10};
      8: info = {2'd1, 8'h10, 8'h10};
      9: info = {2'd1, 8'h08, 8'h10};
      10: info = {2'd1, 8'h04, 8'h10};
      11: info = {2'd1, 8'h20, 8'h08};
      12: info = {2'd1, 8'h02, 8'h40};
      13: info = {2'd2, 8'h80, 8'h80};
      14: info = {2'd2, 8'h40, 8'h80};
      15: info = {2'd2, 8'h20, 8'h80};
      16: info = {2'd2, 8'h10, 8'h80};
      17: info = {2'd2, 8'h08, 8'h08};
      18: info = {2'd0, 8'h20, 8'h20};
      19: info = {2'd2, 8'h05, 8'h02};
      20: info = {2'd2, 8'h02, 8'h02};
      default: info = {2'd2, 8'h04, 8'h02};
    endcase
  endfunction

  task automatic fire(input int i);
    @(posedge clk);
    if (i < 6) ev[i] <= 1'b1;
    else if (i < 11) cnt[i-6] <= 8'hFF;
    else if (i < 18) lv[i-11] <= ~lv[i-11];
    // A clean alignment signal first, so one errored one alone is silent
    else if (i == 18) {aerr, rx_fas} <= 2'b01;
    else begin
      rx_valid <= 1'b1;
      rx_byte <= (i == 20) ? 8'h5A : 8'hA3;
      rx_sel <= (i == 19);
    end
    @(posedge clk);
    ev <= '0;
    {aerr, rx_fas, rx_valid} <= 3'b000;
    if (i >= 6 && i < 11) cnt[i-6] <= 8'h00;
    if (i == 18) begin
      @(posedge clk);
      {aerr, rx_fas} <= 2'b11;
      @(posedge clk);
      {aerr, rx_fas} <= 2'b00;
      @(posedge clk);
      `CHK(vec, 8'h00)
      {aerr, rx_fas} <= 2'b11;
      @(posedge clk);
      {aerr, rx_fas} <= 2'b00;
    end
  endtask

  task automatic run_one(input int i, input logic [7:0] e0, e1, e2);
    logic [17:0] f;
    logic [7:0] w, x;
    f = info(i);
    host.wr(8'h1C, e0);
    host.wr(8'h1D, e1);
    host.wr(8'h1E, e2);
    @(posedge clk);
    lv[5:1] <= 5'b00000;
    repeat (2) @(posedge clk);
    `CHK(vec, 8'h00)
    fire(i);
    repeat (4) @(posedge clk);
    w = (f[17:16] == 2'd0) ? e0 : (f[17:16] == 2'd1) ? e1 : e2;
    x = |(w & f[15:8]) ? f[7:0] : 8'h00;
    `CHK(vec, x)
    `CHK(oe, |x)
    host.rd(8'h21, d);
    `CHK(d, x)
    `CHK(vec, 8'h00)
  endtask

  task stop_test;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      stop_test;
    end
  end

  initial begin
    reset = 1'b1;
    void'($urandom(32'hAADB));
    {aerr, rx_valid, rx_fas, rx_sel, ev, lv} = '0;
    rx_byte = 8'h00;
    foreach (cnt[k]) cnt[k] = 8'h00;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    for (int k = 0; k < 5; k++) begin
      host.rd((k < 3) ? 8'h1C + k[7:0] : (k == 3) ? 8'h21 : 8'h30, d);
      `CHK(d, 8'h00)
    end
    for (int k = 0; k < 3; k++) begin
      host.wr(8'h1C + k[7:0], 8'hFF);
      host.rd(8'h1C + k[7:0], d);
      `CHK(d, (k == 0) ? 8'hFD : (k == 1) ? 8'hFE : 8'hFF)
    end
    host.wr(8'h18, 8'hA5);
    host.wr(8'h19, 8'hF0);
    host.wr(8'h20, 8'hA5);
    for (int i = 0; i < 22; i++) begin
      run_one(i, 8'hFF, 8'hFF, 8'hFF);
      run_one(i, 8'h00, 8'h00, 8'h00);
    end
    repeat (60) begin
      r = $urandom;
      run_one($urandom_range(21, 0), r[7:0], r[15:8], r[23:16]);
    end
    // Suspend drops new events but keeps what is already pending
    host.wr(8'h1C, 8'hFF);
    host.wr(8'h1A, 8'hFF);
    host.rd(8'h1A, d);
    `CHK(d, 8'h40)
    fire(4);
    repeat (4) @(posedge clk);
    `CHK(vec, 8'h00)
    host.wr(8'h1A, 8'h00);
    @(posedge clk);
    ev[4] <= 1'b1;
    ev[5] <= 1'b1;
    @(posedge clk);
    ev <= '0;
    host.wr(8'h1A, 8'h40);
    repeat (2) @(posedge clk);
    `CHK({oe, out_n, vec}, {2'b00, 8'h21})
    host.wr(8'h1A, 8'h00);
    repeat (2) @(posedge clk);
    `CHK(oe, 1'b1)
    host.rd(8'h21, d);
    `CHK(d, 8'h21)
    stop_test;
  end
endmodule
